//--- design/interval_timer_pkg.sv
// package: register map, field layout and reset values of the interval timer
package interval_timer_pkg;
    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] ADDR_INTERVAL_TIMER_COUNT = 12'h000;
    localparam logic [11:0] ADDR_QUADRATURE_CONTROL   = 12'h004;
    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int          RATE_DIV_LSB          = 0;
    localparam int          RATE_DIV_WIDTH        = 3;
    localparam logic [31:0] COUNT_RESET           = 32'h00000000;
    localparam logic [2:0]  RATE_DIV_RESET        = 3'h0;
    localparam logic [31:0] UNMAPPED_READ         = 32'h00000000;
endpackage

//--- design/rate_divider.sv
// rate divider: one-cycle enable pulse every 2**sel clock cycles
`timescale 1ns/10ps
module rate_divider
    import interval_timer_pkg::*;
#(
    parameter int SEL_W = RATE_DIV_WIDTH
) (
    input  wire logic             i_clk,    // system clock
    input  wire logic             i_reset,  // async reset, active high
    input  wire logic             i_sync,   // restart prescaler phase
    input  wire logic [SEL_W-1:0] i_sel,    // divide by 2**i_sel
    output logic                  o_tick    // one-cycle count enable
);
    localparam int PW = (1 << SEL_W);

    logic [PW-1:0] pre_ff;
    logic [PW-1:0] mask;
    logic          hit;

    always_comb begin
        mask = PW'((PW+1)'(1) << i_sel) - PW'(1);
        hit  = ((pre_ff & mask) == mask);
    end

    // restart on each count pulse so a new interval starts on a full period
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pre_ff <= '0;
        end else if (i_sync || hit) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + PW'(1);
        end
    end

    always_comb begin
        o_tick = hit && !i_sync;
    end
endmodule

//--- design/quadrature_interval_timer.sv
// quadrature interval timer: apb slave, rate-divided 32-bit interval counter
`timescale 1ns/10ps
// Contract
// R01: keep a 32-bit counter of time between consecutive decoded count pulses
// R02: clear the counter to zero on each count pulse, no software needed
// R03: after a clear, count at the rate chosen by the divider field
// R04: software picks a slow enough rate so slow motors do not overflow
// R05: all 32 count bits readable and writable, zero after reset
// R06: with no pulse, the counter wraps from all ones to zero and continues
module quadrature_interval_timer
    import interval_timer_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        i_clk,          // 20 mhz clock
    input  wire logic        i_reset,        // async reset, active high
    input  wire logic        i_count_pulse,  // decoded quadrature count strobe
    input  wire logic        i_psel,         // apb select
    input  wire logic        i_penable,      // apb enable
    input  wire logic        i_pwrite,       // apb direction
    input  wire logic [11:0] i_paddr,        // apb byte address
    input  wire logic [31:0] i_pwdata,       // apb write data
    input  wire logic [3:0]  i_pstrb,        // apb byte strobes
    output logic             o_pready,       // apb ready
    output logic [31:0]      o_prdata,       // apb read data
    output logic             o_pslverr,      // apb error
    output logic [2:0]       o_rate_div      // divider setting to decoder
);
    // ************************************************************
    // bus decode
    // ************************************************************
    logic                      setup;
    logic                      wr_cnt;
    logic                      wr_ctl;
    logic                      tick;
    logic                      pready_ff;
    logic [CNT_W-1:0]          count_ff;
    logic [RATE_DIV_WIDTH-1:0] rate_div_ff;
    logic [31:0]               cnt_merge;
    logic [31:0]               ctl_merge;

    // one wait state: answer in the cycle after the first access cycle
    always_comb begin
        setup  = i_psel && i_penable && !pready_ff;
        wr_cnt = setup && i_pwrite && (i_paddr == ADDR_INTERVAL_TIMER_COUNT);
        wr_ctl = setup && i_pwrite && (i_paddr == ADDR_QUADRATURE_CONTROL);
        for (int b = 0; b < 4; b++) begin
            cnt_merge[8*b +: 8] = i_pstrb[b] ? i_pwdata[8*b +: 8] : 8'(count_ff >> (8*b));
            ctl_merge[8*b +: 8] = 8'h00;
        end
        ctl_merge[RATE_DIV_WIDTH-1:0] = i_pstrb[0] ?
            i_pwdata[RATE_DIV_LSB +: RATE_DIV_WIDTH] : rate_div_ff;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
        end
    end

    // writes to a hole are flagged too, so a preset that went nowhere is visible
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_pslverr <= !((i_paddr == ADDR_INTERVAL_TIMER_COUNT) ||
                           (i_paddr == ADDR_QUADRATURE_CONTROL));
            if (i_pwrite) begin
                o_prdata <= 32'h00000000;
            end else if (i_paddr == ADDR_INTERVAL_TIMER_COUNT) begin
                o_prdata <= 32'(count_ff); // R05
            end else if (i_paddr == ADDR_QUADRATURE_CONTROL) begin
                o_prdata <= 32'(rate_div_ff);
            end else begin
                o_prdata <= UNMAPPED_READ;
            end
        end else begin
            o_pslverr <= 1'b0;
        end
    end

    always_comb begin
        o_pready = pready_ff;
    end

    // ************************************************************
    // bus checks
    // ************************************************************
    chk_ready_single: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        o_pready |=> !o_pready)
        else $error("ready held past one cycle");

    chk_unmapped_err: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && (i_paddr != ADDR_INTERVAL_TIMER_COUNT) &&
         (i_paddr != ADDR_QUADRATURE_CONTROL)) |=> (o_pready && o_pslverr))
        else $error("unmapped access not flagged");

    chk_mapped_ok: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && ((i_paddr == ADDR_INTERVAL_TIMER_COUNT) ||
         (i_paddr == ADDR_QUADRATURE_CONTROL))) |=> (o_pready && !o_pslverr))
        else $error("mapped access flagged");

    chk_err_read_zero: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && !i_pwrite && (i_paddr != ADDR_INTERVAL_TIMER_COUNT) &&
         (i_paddr != ADDR_QUADRATURE_CONTROL)) |=> (o_prdata == UNMAPPED_READ))
        else $error("unmapped read not zero");

    chk_write_reads_zero: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && i_pwrite) |=> (o_prdata == 32'h00000000))
        else $error("write returned data");

    chk_unmapped_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && i_pwrite && (i_paddr != ADDR_INTERVAL_TIMER_COUNT) &&
         (i_paddr != ADDR_QUADRATURE_CONTROL)) |=> $stable(rate_div_ff))
        else $error("unmapped write changed divider");

    // ************************************************************
    // control register
    // ************************************************************
    // a new divider does not restart the prescaler, so the interval in progress
    // may see one short period; software reads intervals after a count pulse
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rate_div_ff <= RATE_DIV_RESET;
        end else if (wr_ctl) begin
            rate_div_ff <= ctl_merge[RATE_DIV_WIDTH-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rate_div <= RATE_DIV_RESET;
        end else begin
            o_rate_div <= rate_div_ff;
        end
    end

    chk_ctl_write: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (wr_ctl && i_pstrb[0]) |=> (rate_div_ff == $past(i_pwdata[RATE_DIV_LSB +: RATE_DIV_WIDTH])))
        else $error("divider write lost");

    chk_ctl_read: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (setup && !i_pwrite && i_paddr == ADDR_QUADRATURE_CONTROL) |=> (o_prdata == 32'($past(rate_div_ff))))
        else $error("divider read wrong");

    chk_rate_copy: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        1'b1 |=> (o_rate_div == $past(rate_div_ff)))
        else $error("divider output lags wrongly");

    // ************************************************************
    // interval counter
    // ************************************************************
    rate_divider #(
        .SEL_W (RATE_DIV_WIDTH)
    ) u_div (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_sync  (i_count_pulse),
        .i_sel   (rate_div_ff),
        .o_tick  (tick)
    );

    // a count pulse beats a software write in the same cycle: the hardware
    // measurement must not be corrupted by a stale preset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_ff <= CNT_W'(COUNT_RESET); // R05
        end else if (i_count_pulse) begin
            count_ff <= '0; // R02
        end else if (wr_cnt) begin
            count_ff <= CNT_W'(cnt_merge); // R05
        end else if (tick) begin
            count_ff <= count_ff + CNT_W'(1); // R01 R03 R06
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_pulse_clears: assert property (@(posedge i_clk) disable iff (i_reset) // R02
        i_count_pulse |=> (count_ff == '0))
        else $error("count not cleared after pulse");

    chk_count_step: assert property (@(posedge i_clk) disable iff (i_reset) // R01
        (!i_count_pulse && !wr_cnt && tick) |=> (count_ff == $past(count_ff) + CNT_W'(1)))
        else $error("count did not step on tick");

    chk_hold_no_tick: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (!i_count_pulse && !wr_cnt && !tick) |=> $stable(count_ff))
        else $error("count moved without tick");

    chk_div0_rate: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (rate_div_ff == '0 && !i_count_pulse) |-> tick)
        else $error("divide-by-one missed a tick");

    chk_div1_rate: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (i_count_pulse && rate_div_ff == 3'h1 && !wr_ctl) ##1
        (!i_count_pulse && !wr_ctl) [*2] |-> (!$past(tick) && tick))
        else $error("divide-by-two tick misplaced");

    chk_wrap_zero: assert property (@(posedge i_clk) disable iff (i_reset) // R06
        (&count_ff && tick && !i_count_pulse && !wr_cnt) |=> (count_ff == '0))
        else $error("counter did not wrap");

    chk_write_full: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (wr_cnt && !i_count_pulse && i_pstrb == 4'hf) |=> (count_ff == $past(i_pwdata)))
        else $error("count write lost");

    chk_read_answer: assert property (@(posedge i_clk) disable iff (i_reset) // R05
        (setup && !i_pwrite && i_paddr == ADDR_INTERVAL_TIMER_COUNT)
        |=> (o_pready && o_prdata == $past(count_ff)))
        else $error("count read wrong");

    chk_clear_no_tick: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (i_count_pulse && rate_div_ff != '0 && !wr_ctl) |=> !tick)
        else $error("tick right after clear");

    chk_tick_gap: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (tick && rate_div_ff != '0 && !wr_ctl) |=> !tick)
        else $error("ticks too close together");

    chk_div_max: assert property (@(posedge i_clk) disable iff (i_reset) // R03
        (i_count_pulse && rate_div_ff == 3'h7 && !wr_ctl) ##1
        (!i_count_pulse && !wr_ctl) [*8] |-> !tick)
        else $error("slowest rate ticked early");
endmodule

//--- tb/encoder_model.sv
// shaft encoder model: turns bench steps into decoded count strobes
`timescale 1ns/10ps
module encoder_model (
    input  wire logic i_clk,   // clock
    input  wire logic i_reset, // async reset
    input  wire logic i_step,  // one shaft step
    input  wire logic i_stall, // dither on an edge: strobe held high
    output logic      o_pulse  // decoded count strobe
);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) o_pulse <= 1'b0;
        else o_pulse <= i_step | i_stall;
    end
endmodule

//--- tb/tb_quadrature_interval_timer.sv
// testbench: apb checks of the interval timer against an encoder model
`timescale 1ns/10ps
module tb_quadrature_interval_timer;
    import interval_timer_pkg::*;
    logic i_clk, i_reset, psel, pen, pwr, step, stall, pulse, o_pready, o_pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, o_prdata, r;
    logic [2:0]  o_rate_div;
    logic [15:0] seed;
    logic [3:0]  strb;
    logic [32:0] q[$];
    int          mismatches, check_count;
    encoder_model enc_u (.i_clk(i_clk), .i_reset(i_reset), .i_step(step),
                         .i_stall(stall), .o_pulse(pulse));
    quadrature_interval_timer dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_count_pulse(pulse),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(strb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .o_rate_div(o_rate_div));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_div(input logic [2:0] e, input logic [2:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a transfer notes its expected {error, data}; the monitor pairs it with pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge i_clk);
        q.push_back(e);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin mismatches++; final_report(); end
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic hit();
        @(posedge i_clk) step <= 1'b1;
        @(posedge i_clk) step <= 1'b0;
    endtask
    always @(posedge i_clk) begin
        if (o_pready === 1'b1) begin
            if (q.size() == 0) cmp(33'h0, {o_pslverr, o_prdata});
            else cmp(q.pop_front(), {o_pslverr, o_prdata});
        end
    end
    initial begin
        {psel, pen, pwr, step, stall, paddr, pwdata} = '0;
        strb = 4'hf;
        mismatches = 0; check_count = 0; seed = 16'h701a;
        i_reset = 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        // divide-by-one ticks from release: two steps land before the access edge
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, {1'b0, COUNT_RESET + 32'h2});
        apb(0, ADDR_QUADRATURE_CONTROL, 0, 33'(RATE_DIV_RESET));
        apb(1, 12'h008, 32'h5a, {1'b1, 32'h0});
        apb(0, 12'h008, 0, {1'b1, UNMAPPED_READ});
        $display("reset and map test done");
        // slower rates keep long intervals from wrapping
        for (int d = 1; d <= 6; d++) begin
            apb(1, ADDR_QUADRATURE_CONTROL, 32'hfffffff8 | d, 33'h0);
            apb(0, ADDR_QUADRATURE_CONTROL, 0, 33'(d));
            cmp_div(3'(d), o_rate_div);
            hit();
            repeat ((3 << d) + (1 << (d - 1)) - 2) @(posedge i_clk);
            apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, 33'h3);
        end
        $display("rate test done");
        apb(1, ADDR_QUADRATURE_CONTROL, 32'h7, 33'h0);
        hit();
        seed = lfsr(seed); r[31:16] = seed; seed = lfsr(seed); r[15:0] = seed;
        apb(1, ADDR_INTERVAL_TIMER_COUNT, r, 33'h0);
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, {1'b0, r});
        strb <= 4'h3;
        apb(1, ADDR_INTERVAL_TIMER_COUNT, ~r, 33'h0);
        strb <= 4'hf;
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, {1'b0, r[31:16], ~r[15:0]});
        apb(1, ADDR_INTERVAL_TIMER_COUNT, 32'hffffffff, 33'h0);
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, 33'hffffffff);
        repeat (150) @(posedge i_clk);
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, 33'h0);
        $display("write and wrap test done");
        apb(1, ADDR_INTERVAL_TIMER_COUNT, ~r, 33'h0);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, {1'b0, COUNT_RESET + 32'h2});
        apb(0, ADDR_QUADRATURE_CONTROL, 0, 33'(RATE_DIV_RESET));
        cmp_div(RATE_DIV_RESET, o_rate_div);
        $display("mid-run reset test done");
        apb(1, ADDR_QUADRATURE_CONTROL, 32'h0, 33'h0);
        @(posedge i_clk) stall <= 1'b1;
        repeat (6) @(posedge i_clk);
        apb(0, ADDR_INTERVAL_TIMER_COUNT, 0, 33'h0);
        stall <= 1'b0;
        $display("held strobe test done");
        repeat (3) @(posedge i_clk);
        final_report();
    end
endmodule
